// >>> verilog/fkas_pkg.sv
// constants and types of the flash key and array select block
package fkas_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [11:0] FKAS_OFF_KEY = 12'h000;
   localparam logic [11:0] FKAS_OFF_CCS = 12'h004;
   localparam logic [11:0] FKAS_OFF_SEL = 12'h008;
   localparam logic [11:0] FKAS_OFF_STAT = 12'h00c;

   // ----------------------------------------------------------------
   // field layout and values
   // ----------------------------------------------------------------
   localparam int FKAS_REG_W = 8;
   localparam int FKAS_DLREQ_BIT = 0;
   localparam logic [7:0] FKAS_KEY_DL = 8'ha5;
   localparam logic [7:0] FKAS_KEY_PE = 8'h5a;
   localparam logic [7:0] FKAS_KEY_RST = 8'h00;
   localparam logic [7:0] FKAS_SEL_BOOT = 8'haa;
   localparam logic [7:0] FKAS_SEL_RST = 8'h00;

   // status register bit positions
   localparam int FKAS_ST_DL_OK = 0;
   localparam int FKAS_ST_PE_OK = 1;
   localparam int FKAS_ST_BOOT = 2;
   localparam int FKAS_ST_PE_ALLOW = 3;
   localparam int FKAS_ST_DL_BUSY = 4;
   localparam int FKAS_ST_CAPT = 5;
   localparam int FKAS_ST_MODE_LO = 6;

   // edges after reset release before the start mode strap is taken
   localparam logic [1:0] FKAS_CAPT_WAIT = 2'h2;

   // ----------------------------------------------------------------
   // start-up modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FKAS_MODE_USER,
      FKAS_MODE_USER_BOOT,
      FKAS_MODE_BOOT,
      FKAS_MODE_PROGRAMMER
   } fkas_mode_e;

endpackage : fkas_pkg

// >>> verilog/fkas_perm_if.sv
// signals between the register core and the permission decoder
`timescale 1ns/1ps
interface fkas_perm_if;
   import fkas_pkg::*;
   logic [7:0] key;
   logic [7:0] sel;
   fkas_mode_e mode;
   logic dl_key_ok;
   logic pe_key_ok;
   logic boot_sel;
   logic pe_allowed;

   modport core (output key, output sel, output mode,
                 input dl_key_ok, input pe_key_ok, input boot_sel, input pe_allowed);
   modport gate (input key, input sel, input mode,
                 output dl_key_ok, output pe_key_ok, output boot_sel, output pe_allowed);
endinterface : fkas_perm_if

// >>> verilog/fkas_gate.sv
// permission decoder: key comparisons and array choice
`timescale 1ns/1ps
module fkas_gate (
   // link to the register core
   fkas_perm_if.gate perm
);
   import fkas_pkg::*;

   wire mode_may_prog_boot;

   // compared against the live key every cycle, never latched
   assign perm.dl_key_ok = (perm.key == FKAS_KEY_DL);
   assign perm.pe_key_ok = (perm.key == FKAS_KEY_PE);
   assign perm.boot_sel = (perm.sel == FKAS_SEL_BOOT);
   assign mode_may_prog_boot = (perm.mode == FKAS_MODE_BOOT) ||
                               (perm.mode == FKAS_MODE_PROGRAMMER);
   assign perm.pe_allowed = perm.pe_key_ok &&
                            (!perm.boot_sel || mode_may_prog_boot);

endmodule : fkas_gate

// >>> verilog/fkas_top.sv
// flash key and array select registers behind an apb slave
`timescale 1ns/1ps
module fkas_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // chip state
   input wire logic [1:0] start_mode,
   input wire logic ram_exec,
   input wire logic download_done,
   // flash control
   output logic download_req,
   output logic prog_erase_en,
   output logic boot_array_sel
);
   import fkas_pkg::*;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
      addr_hit = (a == off);
   endfunction : addr_hit

   wire hit_key = addr_hit(paddr, FKAS_OFF_KEY);
   wire hit_ccs = addr_hit(paddr, FKAS_OFF_CCS);
   wire hit_sel = addr_hit(paddr, FKAS_OFF_SEL);
   wire hit_stat = addr_hit(paddr, FKAS_OFF_STAT);
   wire hit_any = hit_key || hit_ccs || hit_sel || hit_stat;
   wire setup_ph = psel && !penable;
   wire access_ph = psel && penable;
   wire wr_en = access_ph && pwrite && hit_any && pstrb[0];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] key_r;
   logic [7:0] sel_r;
   logic [7:0] sel_nxt;
   logic dl_req_r;
   logic dl_req_nxt;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   logic [1:0] mode_s1_r;
   logic [1:0] mode_s2_r;
   fkas_mode_e mode_r;
   logic capt_r;
   logic [1:0] capt_cnt_r;

   fkas_perm_if perm ();

   assign perm.key = key_r;
   assign perm.sel = sel_r;
   assign perm.mode = mode_r;

   fkas_gate u_gate (
      .perm (perm.gate)
   );

   // ----------------------------------------------------------------
   // start mode strap, synchronised then caught once after reset
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode_s1_r <= 2'h0;
         mode_s2_r <= 2'h0;
      end else begin
         mode_s1_r <= start_mode;
         mode_s2_r <= mode_s1_r;
      end
   end

   wire capt_now = !capt_r && (capt_cnt_r == FKAS_CAPT_WAIT);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         capt_cnt_r <= 2'h0;
         capt_r <= 1'b0;
         mode_r <= FKAS_MODE_USER;
      end else if (capt_now) begin
         capt_r <= 1'b1;
         mode_r <= fkas_mode_e'(mode_s2_r);
      end else if (!capt_r) begin
         capt_cnt_r <= capt_cnt_r + 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // key register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         key_r <= FKAS_KEY_RST;
      end else if (wr_en && hit_key) begin
         key_r <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // array select register
   // ----------------------------------------------------------------
   // initial value only exists once the strap is known, so writes wait for it
   wire sel_wr_ok = wr_en && hit_sel && ram_exec && capt_r;

   always_comb begin
      sel_nxt = sel_r;
      if (capt_now && (fkas_mode_e'(mode_s2_r) == FKAS_MODE_USER_BOOT)) begin
         sel_nxt = FKAS_SEL_BOOT;
      end else if (sel_wr_ok && (mode_r != FKAS_MODE_USER)) begin
         sel_nxt = sel_r | pwdata[7:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sel_r <= FKAS_SEL_RST;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // ----------------------------------------------------------------
   // download request
   // ----------------------------------------------------------------
   wire dl_set = wr_en && hit_ccs && pwdata[FKAS_DLREQ_BIT] && ram_exec &&
                 perm.dl_key_ok;

   always_comb begin
      dl_req_nxt = dl_req_r;
      if (dl_set) begin
         dl_req_nxt = 1'b1;
      end else if (download_done) begin
         dl_req_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dl_req_r <= 1'b0;
      end else begin
         dl_req_r <= dl_req_nxt;
      end
   end

   // ----------------------------------------------------------------
   // read data, taken in the setup phase so access completes at once
   // ----------------------------------------------------------------
   wire [7:0] stat_val = {mode_r, capt_r, dl_req_r, perm.pe_allowed,
                          perm.boot_sel, perm.pe_key_ok, perm.dl_key_ok};

   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (hit_key) begin
         rd_nxt[7:0] = key_r;
      end else if (hit_sel) begin
         rd_nxt[7:0] = sel_r;
      end else if (hit_stat) begin
         rd_nxt[7:0] = stat_val;
      end
      // control/status word reads zero: the request bit is write-only
      if (hit_ccs) begin
         rd_nxt = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_r <= rd_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = access_ph && !hit_any;
   assign download_req = dl_req_r;
   assign prog_erase_en = perm.pe_allowed;
   assign boot_array_sel = perm.boot_sel;

endmodule : fkas_top

// >>> dv/fkas_chk.sv
// assertion checker for the flash key and array select block
`timescale 1ns/1ps
module fkas_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // apb and chip state
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic [1:0] start_mode,
   input wire logic download_done,
   // flash control
   input wire logic download_req,
   input wire logic prog_erase_en,
   input wire logic boot_array_sel
);
   import fkas_pkg::*;
   logic [7:0] key_r;
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   wire wr = acc && pwrite && pstrb[0];
   wire set_req = wr && paddr == FKAS_OFF_CCS && pwdata[0];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // shadow of the key so no check needs to peek inside
   always_ff @(posedge core_clk) begin
      if (!rst_n) key_r <= 8'h00;
      else if (wr && paddr == FKAS_OFF_KEY) key_r <= pwdata[7:0];
   end
   a_dl_key_gate: assert property ($rose(download_req) |->
      $past(set_req) && $past(key_r) == FKAS_KEY_DL)
      else $error("download request set without unlock key");
   a_dl_clear: assert property (download_done && !set_req |=> !download_req)
      else $error("download request not cleared");
   a_ccs_zero: assert property (rd && paddr == FKAS_OFF_CCS |-> prdata == 32'h0)
      else $error("control word not read as zero");
   a_key_readback: assert property (rd && paddr == FKAS_OFF_KEY |->
      prdata == {24'h0, key_r})
      else $error("key read differs from written key");
   a_pe_key_only: assert property (prog_erase_en |-> key_r == FKAS_KEY_PE)
      else $error("program enable without key");
   a_pe_main_ok: assert property (key_r == FKAS_KEY_PE && !boot_array_sel |->
      prog_erase_en)
      else $error("program enable missing");
   a_boot_mode: assert property (prog_erase_en && boot_array_sel |-> start_mode[1])
      else $error("boot array programmable in user mode");
   a_sel_on_write: assert property ($changed(boot_array_sel) && start_mode != 2'h1 |->
      $past(wr && paddr == FKAS_OFF_SEL))
      else $error("array choice changed without write");
   a_user_lock: assert property (start_mode == 2'h0 |-> !boot_array_sel)
      else $error("array select changed in user mode");
endmodule : fkas_chk

// >>> dv/tb_top.sv
// self-checking bench for the flash key and array select block
`timescale 1ns/1ps
module tb_top;
   import fkas_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [1:0] start_mode = 2'h0;
   logic ram_exec = 1'b1;
   logic download_done = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, download_req, prog_erase_en, boot_array_sel;
   int miscompares = 0;
   int n_checks = 0;
   fkas_top u_fkas_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .start_mode(start_mode), .ram_exec(ram_exec),
      .download_done(download_done), .download_req(download_req),
      .prog_erase_en(prog_erase_en), .boot_array_sel(boot_array_sel));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic finish_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one apb transfer; an idle cycle follows so no strobe is driven twice in a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= 4'h1;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         miscompares++;
         finish_test();
      end
      @(posedge core_clk);
   endtask : apb
   // restart with a new mode strap and let its capture pass
   task automatic restart(input logic [1:0] m);
      rst_n <= 1'b0;
      start_mode <= m;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask : restart
   initial begin
      restart(2'h0);
      apb(1'b0, FKAS_OFF_KEY, 8'h00);
      chk("key reset", rd, 32'h0);
      apb(1'b1, FKAS_OFF_KEY, 8'hc3);
      apb(1'b0, FKAS_OFF_KEY, 8'h00);
      chk("key rw", rd, 32'hc3);
      apb(1'b0, 12'h010, 8'h00);
      chk("unmapped err", 32'(err), 32'h1);
      apb(1'b1, FKAS_OFF_KEY, FKAS_KEY_PE);
      chk("pe open", 32'(prog_erase_en), 32'h1);
      apb(1'b1, FKAS_OFF_CCS, 8'h01);
      chk("req bad key", 32'(download_req), 32'h0);
      apb(1'b1, FKAS_OFF_KEY, FKAS_KEY_DL);
      chk("pe shut", 32'(prog_erase_en), 32'h0);
      // request from outside on-chip ram is dropped even with the right key
      ram_exec <= 1'b0;
      apb(1'b1, FKAS_OFF_CCS, 8'h01);
      chk("req off ram", 32'(download_req), 32'h0);
      ram_exec <= 1'b1;
      apb(1'b1, FKAS_OFF_CCS, 8'h01);
      chk("req set", 32'(download_req), 32'h1);
      apb(1'b0, FKAS_OFF_CCS, 8'h00);
      chk("ccs read", rd, 32'h0);
      download_done <= 1'b1;
      @(posedge core_clk);
      download_done <= 1'b0;
      @(posedge core_clk);
      chk("req cleared", 32'(download_req), 32'h0);
      apb(1'b1, FKAS_OFF_SEL, FKAS_SEL_BOOT);
      chk("user sel lock", 32'(boot_array_sel), 32'h0);
      $display("test user_mode done");
      restart(2'h2);
      // a select write while not running from ram must not land
      ram_exec <= 1'b0;
      apb(1'b1, FKAS_OFF_SEL, FKAS_SEL_BOOT);
      chk("sel off ram", 32'(boot_array_sel), 32'h0);
      ram_exec <= 1'b1;
      apb(1'b1, FKAS_OFF_SEL, FKAS_SEL_BOOT);
      chk("boot sel", 32'(boot_array_sel), 32'h1);
      apb(1'b1, FKAS_OFF_KEY, FKAS_KEY_PE);
      chk("boot prog", 32'(prog_erase_en), 32'h1);
      apb(1'b0, FKAS_OFF_STAT, 8'h00);
      chk("status word", rd, 32'hae);
      apb(1'b1, FKAS_OFF_SEL, 8'h00);
      apb(1'b0, FKAS_OFF_SEL, 8'h00);
      chk("sel no clear", rd, 32'haa);
      apb(1'b1, FKAS_OFF_SEL, 8'h01);
      chk("sel main", 32'(boot_array_sel), 32'h0);
      $display("test boot_mode done");
      restart(2'h1);
      chk("ub sel", 32'(boot_array_sel), 32'h1);
      apb(1'b1, FKAS_OFF_KEY, FKAS_KEY_PE);
      chk("ub prog refused", 32'(prog_erase_en), 32'h0);
      $display("test user_boot done");
      finish_test();
   end
endmodule : tb_top
bind fkas_top fkas_chk u_fkas_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .start_mode(start_mode), .download_done(download_done),
   .download_req(download_req), .prog_erase_en(prog_erase_en), .boot_array_sel(boot_array_sel));
